// *** verilog/gplc_cfg.svh ***
// Register offsets, field positions, reset values and timing counts for the port link control
`ifndef GPLC_CFG_SVH
`define GPLC_CFG_SVH
`define GPLC_OFS_ALL     12'h000
`define GPLC_OFS_STAT    12'h004
`define GPLC_OFS_PORT0   12'h010
`define GPLC_PORT_STRIDE 12'h010
`define GPLC_OFS_CFG     4'h0
`define GPLC_OFS_LINK    4'h4
`define GPLC_OFS_BUF     4'h8
`define GPLC_F_EN        0
`define GPLC_F_SD_LO     4
`define GPLC_F_SD_HI     6
`define GPLC_F_FC        8
`define GPLC_RST_EN      1'b1
`define GPLC_RST_SD      3'h0
`define GPLC_RST_FC      1'b0
`define GPLC_AN_TIMEOUT_US 32'd1000
`define GPLC_AN_TIMEOUT_CYC ((`GPLC_AN_TIMEOUT_US * 32'd10) > 32'd0 ? (`GPLC_AN_TIMEOUT_US * 32'd10) : 32'd1)
`define GPLC_PAUSE_QUANTA 16'hffff
`endif

// *** verilog/gplc_pkg.sv ***
// Types shared by the port link control files
package gplc_pkg;
  typedef enum logic [2:0] {
    GPLC_SD_AUTO  = 3'h0,
    GPLC_SD_10H   = 3'h1,
    GPLC_SD_10F   = 3'h2,
    GPLC_SD_100H  = 3'h3,
    GPLC_SD_100F  = 3'h4,
    GPLC_SD_1000F = 3'h5
  } gplc_sd_type;
  typedef enum logic [1:0] {
    GPLC_SPD_10   = 2'h0,
    GPLC_SPD_100  = 2'h1,
    GPLC_SPD_1000 = 2'h2
  } gplc_spd_type;
  typedef enum logic [3:0] {
    GPLC_ST_DOWN  = 4'b0001,
    GPLC_ST_NEG   = 4'b0010,
    GPLC_ST_UP    = 4'b0100,
    GPLC_ST_FORCE = 4'b1000
  } gplc_lst_type;
endpackage

// *** verilog/gplc_port.sv ***
// One port: link resolution state machine and flow control drive
`timescale 1ns/1ps
`include "gplc_cfg.svh"
module gplc_port #(
  parameter int unsigned AN_TIMEOUT = `GPLC_AN_TIMEOUT_CYC
) (
  input  wire logic        hclk,
  input  wire logic        hresetn,
  input  wire logic        enable,
  input  wire logic [2:0]  sd_cfg,
  input  wire logic        fc_en,
  input  wire logic        signal_det,
  input  wire logic [1:0]  det_speed,
  input  wire logic        peer_an_valid,
  input  wire logic [4:0]  peer_ability,
  input  wire logic        buf_full,
  input  wire logic        tx_req,
  output logic             link_up_q,
  output logic [1:0]       speed_q,
  output logic             full_dup_q,
  output logic             tx_allow_q,
  output logic             pause_req_q,
  output logic             backpress_q,
  output logic [3:0]       state_q
);
  gplc_pkg::gplc_lst_type st_q;
  logic [31:0]            tmo_q;
  logic                   sig_ok;
  logic [4:0]             common;

  // Local ability bits: 10H,10F,100H,100F,1000F; gigabit half never offered
  assign common = peer_ability & 5'h1f;
  assign sig_ok = enable & signal_det;

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_q       <= gplc_pkg::GPLC_ST_DOWN;
      tmo_q      <= 32'h0;
      link_up_q  <= 1'b0;
      speed_q    <= 2'h0;
      full_dup_q <= 1'b0;
    end else begin
      unique case (st_q)
        gplc_pkg::GPLC_ST_DOWN: begin
          link_up_q <= 1'b0;
          tmo_q     <= 32'h0;
          if (sig_ok) begin
            if (sd_cfg == gplc_pkg::GPLC_SD_AUTO) begin
              st_q <= gplc_pkg::GPLC_ST_NEG;
            end else begin
              st_q <= gplc_pkg::GPLC_ST_FORCE;
            end
          end
        end
        gplc_pkg::GPLC_ST_NEG: begin
          tmo_q <= tmo_q + 32'h1;
          if (!sig_ok || sd_cfg != gplc_pkg::GPLC_SD_AUTO) begin
            st_q <= gplc_pkg::GPLC_ST_DOWN;
          end else if (peer_an_valid && common != 5'h0) begin
            // Best common mode wins
            st_q      <= gplc_pkg::GPLC_ST_UP;
            link_up_q <= 1'b1;
            if (common[4]) begin
              speed_q <= gplc_pkg::GPLC_SPD_1000;
              full_dup_q <= 1'b1;
            end else if (common[3] | common[2]) begin
              speed_q <= gplc_pkg::GPLC_SPD_100;
              full_dup_q <= common[3];
            end else begin
              speed_q <= gplc_pkg::GPLC_SPD_10;
              full_dup_q <= common[1];
            end
          end else if (tmo_q >= AN_TIMEOUT - 1) begin
            // Peer silent: take speed from line, half duplex
            st_q       <= gplc_pkg::GPLC_ST_UP;
            link_up_q  <= 1'b1;
            speed_q    <= det_speed;
            full_dup_q <= 1'b0;
          end
        end
        gplc_pkg::GPLC_ST_FORCE: begin
          st_q      <= gplc_pkg::GPLC_ST_UP;
          link_up_q <= 1'b1;
          unique case (sd_cfg)
            gplc_pkg::GPLC_SD_10H:   begin speed_q <= gplc_pkg::GPLC_SPD_10;   full_dup_q <= 1'b0; end
            gplc_pkg::GPLC_SD_10F:   begin speed_q <= gplc_pkg::GPLC_SPD_10;   full_dup_q <= 1'b1; end
            gplc_pkg::GPLC_SD_100H:  begin speed_q <= gplc_pkg::GPLC_SPD_100;  full_dup_q <= 1'b0; end
            gplc_pkg::GPLC_SD_100F:  begin speed_q <= gplc_pkg::GPLC_SPD_100;  full_dup_q <= 1'b1; end
            default:                 begin speed_q <= gplc_pkg::GPLC_SPD_1000; full_dup_q <= 1'b1; end
          endcase
        end
        gplc_pkg::GPLC_ST_UP: begin
          if (!sig_ok) begin
            st_q      <= gplc_pkg::GPLC_ST_DOWN;
            link_up_q <= 1'b0;
          end
        end
        default: st_q <= gplc_pkg::GPLC_ST_DOWN;
      endcase
    end
  end

  // Transmit only on an enabled port with link
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      tx_allow_q <= 1'b0;
    end else begin
      tx_allow_q <= tx_req & enable & link_up_q;
    end
  end

  // Throttle sender when buffers fill: pause in full, collision jam in half
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      pause_req_q <= 1'b0;
      backpress_q <= 1'b0;
    end else begin
      pause_req_q <= fc_en & link_up_q & full_dup_q & buf_full;
      backpress_q <= fc_en & link_up_q & ~full_dup_q & buf_full;
    end
  end

  assign state_q = st_q;
endmodule

// *** verilog/gplc_top.sv ***
// Multi-port link control with AHB-Lite register access
`timescale 1ns/1ps
`include "gplc_cfg.svh"
module gplc_top #(
  parameter int unsigned N_PORTS    = 12,
  parameter int unsigned AN_TIMEOUT = `GPLC_AN_TIMEOUT_CYC
) (
  input  wire logic               hclk,
  input  wire logic               hresetn,
  input  wire logic               hsel,
  input  wire logic [11:0]        haddr,
  input  wire logic [1:0]         htrans,
  input  wire logic               hwrite,
  input  wire logic [2:0]         hsize,
  input  wire logic [31:0]        hwdata,
  input  wire logic               hready,
  output logic [31:0]             hrdata,
  output logic                    hreadyout,
  output logic                    hresp,
  input  wire logic [N_PORTS-1:0] signal_det,
  input  wire logic [2*N_PORTS-1:0] det_speed,
  input  wire logic [N_PORTS-1:0] peer_an_valid,
  input  wire logic [5*N_PORTS-1:0] peer_ability,
  input  wire logic [N_PORTS-1:0] buf_full,
  input  wire logic [N_PORTS-1:0] tx_req,
  output logic [N_PORTS-1:0]      tx_allow,
  output logic [N_PORTS-1:0]      pause_req,
  output logic [N_PORTS-1:0]      backpress,
  output logic [N_PORTS-1:0]      link_up
);
  //////////////////////////////////////////////////////////////////////////////
  // Pin synchronisers: three stages, change accepted when stages 2 and 3 agree
  localparam int W = 8 * N_PORTS + 2 * N_PORTS;
  logic [W-1:0] s1_q, s2_q, s3_q, in_q;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
      in_q <= '0;
    end else begin
      s1_q <= {signal_det, det_speed, peer_an_valid, peer_ability, buf_full};
      s2_q <= s1_q;
      s3_q <= s2_q;
      for (int i = 0; i < W; i++) begin
        if (s2_q[i] == s3_q[i]) begin
          in_q[i] <= s3_q[i];
        end
      end
    end
  end
  logic [N_PORTS-1:0]   sy_det, sy_anv, sy_full;
  logic [2*N_PORTS-1:0] sy_spd;
  logic [5*N_PORTS-1:0] sy_abl;
  assign {sy_det, sy_spd, sy_anv, sy_abl, sy_full} = in_q;

  //////////////////////////////////////////////////////////////////////////////
  // AHB-Lite slave: zero wait states, always OKAY
  logic        wr_pend_q;
  logic [11:0] wr_addr_q;
  logic        acc;
  assign acc = hsel & hready & htrans[1];

  function automatic logic cfg_hit(input logic [11:0] a, input int p);
    return a == 12'(`GPLC_OFS_PORT0 + p * `GPLC_PORT_STRIDE + `GPLC_OFS_CFG);
  endfunction

  // Gigabit half and spare codes are not storable
  function automatic logic sd_legal(input logic [2:0] v);
    return v <= gplc_pkg::GPLC_SD_1000F;
  endfunction

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_pend_q <= 1'b0;
      wr_addr_q <= 12'h000;
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      wr_pend_q <= acc & hwrite;
      if (acc) begin
        wr_addr_q <= haddr;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Per-port settings
  logic [N_PORTS-1:0] en_q, fc_q;
  logic [2:0]         sd_q [N_PORTS];
  logic [2:0]         all_sd_q;
  logic               all_en_q, all_fc_q;
  logic [2:0]         wsd;
  assign wsd = hwdata[`GPLC_F_SD_HI:`GPLC_F_SD_LO];

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      en_q     <= {N_PORTS{`GPLC_RST_EN}};
      fc_q     <= {N_PORTS{`GPLC_RST_FC}};
      all_en_q <= `GPLC_RST_EN;
      all_fc_q <= `GPLC_RST_FC;
      all_sd_q <= `GPLC_RST_SD;
      for (int p = 0; p < N_PORTS; p++) begin
        sd_q[p] <= `GPLC_RST_SD;
      end
    end else if (wr_pend_q) begin
      if (wr_addr_q == `GPLC_OFS_ALL) begin
        all_en_q <= hwdata[`GPLC_F_EN];
        all_fc_q <= hwdata[`GPLC_F_FC];
        en_q     <= {N_PORTS{hwdata[`GPLC_F_EN]}};
        fc_q     <= {N_PORTS{hwdata[`GPLC_F_FC]}};
        if (sd_legal(wsd)) begin
          all_sd_q <= wsd;
        end
      end
      for (int p = 0; p < N_PORTS; p++) begin
        if (wr_addr_q == `GPLC_OFS_ALL && sd_legal(wsd)) begin
          sd_q[p] <= wsd;
        end else if (cfg_hit(wr_addr_q, p)) begin
          en_q[p] <= hwdata[`GPLC_F_EN];
          fc_q[p] <= hwdata[`GPLC_F_FC];
          if (sd_legal(wsd)) begin
            sd_q[p] <= wsd;
          end
        end
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Port engines
  logic [N_PORTS-1:0] lu, fd, txa, pz, bp;
  logic [1:0]         spd [N_PORTS];
  logic [3:0]         lst [N_PORTS];
  for (genvar g = 0; g < N_PORTS; g++) begin : g_port
    gplc_port #(
      .AN_TIMEOUT (AN_TIMEOUT)
    ) u_port (
      .hclk          (hclk),
      .hresetn       (hresetn),
      .enable        (en_q[g]),
      .sd_cfg        (sd_q[g]),
      .fc_en         (fc_q[g]),
      .signal_det    (sy_det[g]),
      .det_speed     (sy_spd[2*g +: 2]),
      .peer_an_valid (sy_anv[g]),
      .peer_ability  (sy_abl[5*g +: 5]),
      .buf_full      (sy_full[g]),
      .tx_req        (tx_req[g]),
      .link_up_q     (lu[g]),
      .speed_q       (spd[g]),
      .full_dup_q    (fd[g]),
      .tx_allow_q    (txa[g]),
      .pause_req_q   (pz[g]),
      .backpress_q   (bp[g]),
      .state_q       (lst[g])
    );
  end
  assign tx_allow  = txa;
  assign pause_req = pz;
  assign backpress = bp;
  assign link_up   = lu;

  //////////////////////////////////////////////////////////////////////////////
  // Read data, registered at the address phase
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      hrdata <= 32'h0;
    end else if (acc && !hwrite) begin
      hrdata <= 32'h0;
      if (haddr == `GPLC_OFS_ALL) begin
        hrdata[`GPLC_F_EN]                   <= all_en_q;
        hrdata[`GPLC_F_SD_HI:`GPLC_F_SD_LO]  <= all_sd_q;
        hrdata[`GPLC_F_FC]                   <= all_fc_q;
      end else if (haddr == `GPLC_OFS_STAT) begin
        hrdata[N_PORTS-1:0] <= lu;
      end
      for (int p = 0; p < N_PORTS; p++) begin
        if (cfg_hit(haddr, p)) begin
          hrdata[`GPLC_F_EN]                  <= en_q[p];
          hrdata[`GPLC_F_SD_HI:`GPLC_F_SD_LO] <= sd_q[p];
          hrdata[`GPLC_F_FC]                  <= fc_q[p];
        end else if (haddr == 12'(`GPLC_OFS_PORT0 + p * `GPLC_PORT_STRIDE + `GPLC_OFS_LINK)) begin
          hrdata[0]   <= lu[p];
          hrdata[2:1] <= spd[p];
          hrdata[3]   <= fd[p];
          hrdata[7:4] <= lst[p];
        end else if (haddr == 12'(`GPLC_OFS_PORT0 + p * `GPLC_PORT_STRIDE + `GPLC_OFS_BUF)) begin
          hrdata[0] <= sy_full[p];
          hrdata[1] <= pz[p];
          hrdata[2] <= bp[p];
        end
      end
    end
  end
endmodule

// *** test/gplc_monitor.sv ***
// Checker on the top ports of the port link control
`timescale 1ns/1ps
module gplc_monitor #(
  parameter int unsigned N_PORTS = 12
) (
  input wire logic               hclk,
  input wire logic               hresetn,
  input wire logic               hreadyout,
  input wire logic               hresp,
  input wire logic [N_PORTS-1:0] signal_det,
  input wire logic [N_PORTS-1:0] buf_full,
  input wire logic [N_PORTS-1:0] tx_req,
  input wire logic [N_PORTS-1:0] tx_allow,
  input wire logic [N_PORTS-1:0] pause_req,
  input wire logic [N_PORTS-1:0] backpress,
  input wire logic [N_PORTS-1:0] link_up
);
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn);
  AST_READY: assert property (hreadyout && !hresp)
    else $error("bus answer not zero-wait okay");
  AST_TX_REQ: assert property (tx_allow[0] |-> $past(tx_req[0]))
    else $error("transmit allowed without request");
  AST_TX_LINK: assert property (tx_allow[0] |-> $past(link_up[0]))
    else $error("transmit allowed without link");
  AST_FC_EXCL: assert property (pause_req[0] |-> !backpress[0])
    else $error("pause and backpressure together");
  AST_FC_CLEAR: assert property (!buf_full[0] [*8] |-> !pause_req[0] && !backpress[0])
    else $error("throttle without full buffer");
  AST_PAUSE_CAUSE: assert property ($rose(pause_req[0]) |-> $past(buf_full[0], 2))
    else $error("pause without buffer fill");
  AST_BP_CAUSE: assert property ($rose(backpress[1]) |-> $past(buf_full[1], 2))
    else $error("backpressure without buffer fill");
  AST_LINK_DROP: assert property (!signal_det[0] [*8] |-> !link_up[0])
    else $error("link up with no line signal");
  AST_LINK_CAUSE: assert property ($rose(link_up[1]) |-> $past(signal_det[1], 2))
    else $error("link rose without line signal");
endmodule
bind gplc_top gplc_monitor #(.N_PORTS(N_PORTS)) u_mon (
  .hclk(hclk), .hresetn(hresetn), .hreadyout(hreadyout), .hresp(hresp),
  .signal_det(signal_det), .buf_full(buf_full), .tx_req(tx_req), .tx_allow(tx_allow),
  .pause_req(pause_req), .backpress(backpress), .link_up(link_up));

// *** test/gplc_peer.sv ***
// Peer port model: line signal, detected speed and advertised abilities
`timescale 1ns/1ps
module gplc_peer (
  input  wire logic       hclk,
  input  wire logic       rst_n,
  input  wire logic       on,
  input  wire logic       nego,
  input  wire logic [1:0] spd,
  input  wire logic [4:0] abil,
  output logic            sig_det,
  output logic [1:0]      det_spd,
  output logic            an_valid,
  output logic [4:0]      ability
);
  // Lines with nothing behind them toggle rather than keep a stale value
  always_ff @(posedge hclk or negedge rst_n) begin
    if (!rst_n) begin
      sig_det  <= 1'b0;
      det_spd  <= 2'h0;
      an_valid <= 1'b0;
      ability  <= 5'h00;
    end else begin
      sig_det  <= on;
      det_spd  <= on ? spd : ~det_spd;
      an_valid <= on && nego;
      ability  <= (on && nego) ? abil : ~ability;
    end
  end
endmodule

// *** test/gplc_tb_top.sv ***
// Self-checking bench for the port link control
`timescale 1ns/1ps
module gplc_tb_top;
  localparam int unsigned NP = 2;
  logic        hclk, hresetn, hsel, hwrite, hreadyout, hresp;
  logic [11:0] haddr;
  logic [1:0]  htrans;
  logic [31:0] hwdata, hrdata;
  logic [NP-1:0]        on, ng, buf_full, tx_req, tx_allow, pause_req, backpress, link_up;
  logic [2*NP-1:0]      spd;
  logic [5*NP-1:0]      ab;
  wire logic [NP-1:0]   sd, av;
  wire logic [2*NP-1:0] ds;
  wire logic [5*NP-1:0] pa;
  int failures, n_checks;
  initial begin
    hclk = 1'b0;
    forever #50 hclk = ~hclk;
  end
  gplc_top #(.N_PORTS(NP), .AN_TIMEOUT(20)) DUT (
    .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout),
    .hresp(hresp), .signal_det(sd), .det_speed(ds), .peer_an_valid(av), .peer_ability(pa),
    .buf_full(buf_full), .tx_req(tx_req), .tx_allow(tx_allow), .pause_req(pause_req),
    .backpress(backpress), .link_up(link_up));
  for (genvar i = 0; i < NP; i++) begin : g_peer
    gplc_peer u_peer (.hclk(hclk), .rst_n(hresetn), .on(on[i]), .nego(ng[i]), .spd(spd[2*i+:2]),
      .abil(ab[5*i+:5]), .sig_det(sd[i]), .det_spd(ds[2*i+:2]), .an_valid(av[i]),
      .ability(pa[5*i+:5]));
  end
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel   <= 1'b1;
    haddr  <= a;
    hwrite <= wr;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel   <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rc(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, 32'h0, r);
    chk(r, exp);
  endtask
  task automatic wait_link(input int p, input logic v);
    repeat (300) begin
      if (link_up[p] === v) break;
      @(posedge hclk);
    end
    chk(32'(link_up[p]), 32'(v));
    repeat (2) @(posedge hclk);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  task automatic t_reset;
    rc(12'h010, 32'h1);
    rc(12'h020, 32'h1);
    rc(12'hff0, 32'h0);
    wr(12'h000, 32'h101);
    rc(12'h000, 32'h101);
    rc(12'h010, 32'h101);
    rc(12'h020, 32'h101);
    $display("test reset and all-ports row done");
  endtask
  task automatic t_auto;
    {on[0], ng[0], spd[1:0], ab[4:0]} <= {2'b11, 2'h2, 5'b01001};
    wait_link(0, 1'b1);
    rc(12'h014, 32'h4b);
    tx_req[0] <= 1'b1;
    repeat (2) @(posedge hclk);
    chk(32'(tx_allow[0]), 32'h1);
    buf_full[0] <= 1'b1;
    repeat (8) @(posedge hclk);
    chk(32'({pause_req[0], backpress[0]}), 32'h2);
    rc(12'h018, 32'h3);
    buf_full[0] <= 1'b0;
    $display("test negotiated link done");
  endtask
  task automatic t_silent;
    {on[1], ng[1], spd[3:2]} <= {2'b10, 2'h1};
    wait_link(1, 1'b1);
    rc(12'h024, 32'h43);
    rc(12'h004, 32'h3);
    buf_full[1] <= 1'b1;
    repeat (8) @(posedge hclk);
    chk(32'({pause_req[1], backpress[1]}), 32'h1);
    rc(12'h028, 32'h5);
    buf_full[1] <= 1'b0;
    $display("test silent peer done");
  endtask
  task automatic t_force;
    wr(12'h010, 32'h100);
    wait_link(0, 1'b0);
    chk(32'(tx_allow[0]), 32'h0);
    {ng[0], spd[1:0]} <= 3'b000;
    wr(12'h010, 32'h020);
    wr(12'h010, 32'h071);
    rc(12'h010, 32'h021);
    buf_full[0] <= 1'b1;
    wait_link(0, 1'b1);
    rc(12'h014, 32'h49);
    repeat (8) @(posedge hclk);
    chk(32'({pause_req[0], backpress[0]}), 32'h0);
    buf_full[0] <= 1'b0;
    $display("test forced link done");
  endtask
  task automatic t_codes;
    // Expected link word per code: silent peer at 100 for auto, forced mode otherwise
    logic [7:0] lk [8] = '{8'h43, 8'h41, 8'h49, 8'h43, 8'h4b, 8'h4d, 8'h4d, 8'h4d};
    for (int c = 0; c < 8; c++) begin
      wr(12'h020, 32'(c) << 4);
      wait_link(1, 1'b0);
      rc(12'h020, (c < 6) ? 32'(c) << 4 : 32'h50);
      wr(12'h020, (32'(c) << 4) | 32'h1);
      wait_link(1, 1'b1);
      rc(12'h024, 32'(lk[c]));
    end
    $display("test speed codes done");
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  initial begin
    {hresetn, hsel, hwrite, haddr, htrans, hwdata} = '0;
    {on, ng, spd, ab, buf_full, tx_req} = '0;
    repeat (8) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_reset;
    t_auto;
    t_silent;
    t_force;
    t_codes;
    results;
  end
  initial begin
    repeat (20000) @(posedge hclk);
    failures++;
    results;
  end
endmodule
